// file: hw/status_word_flags.sv
// processor status word with an ahb-lite register port
// assumes a single ahb-lite master and the accumulator on the same clock
//
// Design decision made here: the AHB-Lite interface to the registers.
`timescale 1ns/1ps
`include "status_word_map.svh"

// Function
// - half carry set on carry into or borrow from the upper nibble, else cleared
// - overflow set when add, addc or subb gives a wrong result sign
// - overflow set when a multiply product exceeds 255
// - overflow set when a divide has a zero divisor
// - otherwise add, addc, subb, mul and div clear overflow
// - user flag one is a bit-addressable software bit with no hardware effect
// - status word sits at location 0xD0; its stored bits reset to zero while parity keeps following the accumulator
module status_word_flags
  import status_word_pkg::*;
#(
  parameter int ACC_W = 8
)
(
  input  wire logic        sys_clk,
  input  wire logic        reset,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  input  alu_req_type      alu_req,
  input  bit_wr_type       bit_wr,
  input  wire logic [7:0]  acc,
  input  wire logic [2:0]  reg_index,
  output logic [7:0]       status_out,
  output logic [7:0]       work_reg_addr
);

  if (ACC_W != 8)
  begin : g_bad_width
    $error("status_word_flags serves an eight bit accumulator only");
  end

  // ----------------------------------------
  // bus slave
  // ----------------------------------------
  logic        wr_pend_ff;
  logic        rd_hit_ff;
  logic [6:0]  stat_ff;
  logic [31:0] hrdata_ff;
  logic [6:0]  nxt_stat;
  flags_type   alu_flags;

  wire logic addr_phase = hsel && htrans[1] && hready;
  wire logic stat_hit   = haddr == `STAT_ADDR;
  wire logic bus_wr     = wr_pend_ff;
  // parity is not held in stat_ff, so status_out can never disagree with the accumulator
  wire logic parity     = ^acc;

  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign hrdata    = hrdata_ff;

  always_ff @(posedge sys_clk or posedge reset)
  begin
    if (reset)
    begin
      wr_pend_ff <= 1'b0;
      rd_hit_ff  <= 1'b0;
    end
    else
    begin
      wr_pend_ff <= addr_phase && hwrite && stat_hit;
      rd_hit_ff  <= addr_phase && !hwrite && stat_hit;
    end
  end

  // read data is captured from the next value so a write just before is seen
  always_ff @(posedge sys_clk or posedge reset)
  begin
    if (reset)
      hrdata_ff <= 32'h0000_0000;
    else if (addr_phase && !hwrite)
      hrdata_ff <= stat_hit ? {24'h00_0000, nxt_stat, parity} : 32'h0000_0000;
  end

  // ----------------------------------------
  // status word update
  // ----------------------------------------
  flag_calc u_flag_calc
  (
    .req   (alu_req),
    .cy_in (stat_ff[`STAT_CARRY_BIT - 1]),
    .flags (alu_flags)
  );

  // bus write first, then a core bit write, then arithmetic flags on top
  always_comb
  begin
    nxt_stat = stat_ff;
    if (bus_wr)
      nxt_stat = hwdata[7:1];
    if (bit_wr.valid && bit_wr.sel != 3'(`STAT_PARITY_BIT))
      nxt_stat[bit_wr.sel - 3'h1] = bit_wr.val;
    if (alu_req.valid)
    begin
      nxt_stat[`STAT_CARRY_BIT - 1] = alu_flags.carry;
      nxt_stat[`STAT_HALF_BIT - 1]  = alu_flags.half;
      nxt_stat[`STAT_OVF_BIT - 1]   = alu_flags.ovf;
    end
  end

  always_ff @(posedge sys_clk or posedge reset)
  begin
    if (reset)
      stat_ff <= 7'(`STAT_RESET >> 1);
    else
      stat_ff <= nxt_stat;
  end

  assign status_out = {stat_ff, parity};
  // a bank change takes effect next cycle; software must not use it at once
  assign work_reg_addr = {3'h0, stat_ff[`STAT_BANK_HI_BIT - 1 -: 2], reg_index};

  // ----------------------------------------
  // checks
  // ----------------------------------------
  wire logic [4:0] exp_half = {1'b0, alu_req.a[3:0]} + {1'b0, alu_req.b[3:0]};
  wire logic [7:0] exp_sum  = alu_req.a + alu_req.b;
  wire logic [8:0] exp_sub  = {1'b0, alu_req.a} - {1'b0, alu_req.b} - {8'h00, status_out[`STAT_CARRY_BIT]};
  wire logic       mul_big  = ({8'h00, alu_req.a} * {8'h00, alu_req.b}) > 16'h00FF;
  wire logic       is_add   = alu_req.valid && alu_req.op == op_add;

  a_half_carry_add: assert property (@(posedge sys_clk) disable iff (reset)
    is_add |=> status_out[`STAT_HALF_BIT] == $past(exp_half[4]))
    else $error("half carry wrong after add");
  a_overflow_sign: assert property (@(posedge sys_clk) disable iff (reset)
    is_add |=> status_out[`STAT_OVF_BIT] ==
      $past(alu_req.a[7] == alu_req.b[7] && exp_sum[7] != alu_req.a[7]))
    else $error("overflow wrong after add");
  a_overflow_mul: assert property (@(posedge sys_clk) disable iff (reset)
    alu_req.valid && alu_req.op == op_mul && mul_big |=> status_out[`STAT_OVF_BIT])
    else $error("multiply overflow not flagged");
  a_overflow_div: assert property (@(posedge sys_clk) disable iff (reset)
    alu_req.valid && alu_req.op == op_div && alu_req.b == 8'h00 |=> status_out[`STAT_OVF_BIT])
    else $error("divide by zero not flagged");
  a_overflow_clear: assert property (@(posedge sys_clk) disable iff (reset)
    alu_req.valid && ((alu_req.op == op_mul && !mul_big) || (alu_req.op == op_div && alu_req.b != 8'h00))
    |=> !status_out[`STAT_OVF_BIT])
    else $error("overflow not cleared");
  a_user_flag_hold: assert property (@(posedge sys_clk) disable iff (reset)
    !bus_wr && !bit_wr.valid |=> $stable(status_out[`STAT_USER1_BIT]))
    else $error("user flag changed without a write");
  a_parity_read: assert property (@(posedge sys_clk) disable iff (reset)
    addr_phase && !hwrite && stat_hit |=> hrdata[0] == $past(^acc))
    else $error("parity readback wrong");
  a_bus_readback: assert property (@(posedge sys_clk) disable iff (reset)
    bus_wr && !bit_wr.valid && !alu_req.valid ##1 addr_phase && !hwrite && stat_hit && !bit_wr.valid
    && !alu_req.valid |=> hrdata[7:1] == $past(hwdata[7:1], 2))
    else $error("status word readback wrong");
  a_bank_base: assert property (@(posedge sys_clk) disable iff (reset)
    bus_wr && !bit_wr.valid |=> work_reg_addr[4:3] == $past(hwdata[4:3]))
    else $error("bank base does not follow bank select");
  a_carry_subb: assert property (@(posedge sys_clk) disable iff (reset)
    alu_req.valid && alu_req.op == op_subb |=> status_out[`STAT_CARRY_BIT] == $past(exp_sub[8]))
    else $error("borrow wrong after subtract");

  c_add_carry: cover property (@(posedge sys_clk) disable iff (reset) is_add && exp_half[4]);
  c_mul_big:   cover property (@(posedge sys_clk) disable iff (reset)
    alu_req.valid && alu_req.op == op_mul && mul_big);
  c_div_zero:  cover property (@(posedge sys_clk) disable iff (reset)
    alu_req.valid && alu_req.op == op_div && alu_req.b == 8'h00);
  c_stat_read: cover property (@(posedge sys_clk) disable iff (reset) rd_hit_ff);

endmodule

// file: hw/status_word_map.svh
// status word constants: bus offset, reset value and field positions
// assumes a word-addressed bus where each register takes one aligned word
`ifndef STATUS_WORD_MAP_SVH
`define STATUS_WORD_MAP_SVH

`define STAT_ADDR        32'h0000_00D0
`define STAT_RESET       8'h00
`define STAT_CARRY_BIT   7
`define STAT_HALF_BIT    6
`define STAT_USER0_BIT   5
`define STAT_BANK_HI_BIT 4
`define STAT_BANK_LO_BIT 3
`define STAT_OVF_BIT     2
`define STAT_USER1_BIT   1
`define STAT_PARITY_BIT  0
`define BANK_SHIFT      3

`endif

// file: hw/status_word_pkg.sv
// types shared by the status word block and its flag calculator
// assumes no other package is needed
package status_word_pkg;

  typedef enum logic [2:0]
  {
    op_add,
    op_addc,
    op_subb,
    op_mul,
    op_div
  } alu_op_type;

  typedef struct packed
  {
    logic       valid;
    alu_op_type op;
    logic [7:0] a;
    logic [7:0] b;
  } alu_req_type;

  typedef struct packed
  {
    logic carry;
    logic half;
    logic ovf;
  } flags_type;

  typedef struct packed
  {
    logic       valid;
    logic [2:0] sel;
    logic       val;
  } bit_wr_type;

endpackage

// file: hw/flag_calc.sv
// arithmetic flag calculator for the status word
// assumes operands are stable in the cycle the request is valid
`timescale 1ns/1ps

module flag_calc
  import status_word_pkg::*;
(
  input  alu_req_type req,
  input  wire logic   cy_in,
  output flags_type   flags
);

  // ----------------------------------------
  // arithmetic helpers
  // ----------------------------------------
  function automatic logic [8:0] add9(input logic [7:0] x, input logic [7:0] y, input logic c);
    add9 = {1'b0, x} + {1'b0, y} + {8'h00, c};
  endfunction

  function automatic logic [8:0] sub9(input logic [7:0] x, input logic [7:0] y, input logic c);
    sub9 = {1'b0, x} - {1'b0, y} - {8'h00, c};
  endfunction

  wire logic        cin   = (req.op == op_addc || req.op == op_subb) ? cy_in : 1'b0;
  wire logic [8:0]  sum   = add9(req.a, req.b, cin);
  wire logic [8:0]  dif   = sub9(req.a, req.b, cin);
  wire logic [8:0]  hsum  = add9({4'h0, req.a[3:0]}, {4'h0, req.b[3:0]}, cin);
  wire logic [8:0]  hdif  = sub9({4'h0, req.a[3:0]}, {4'h0, req.b[3:0]}, cin);
  wire logic [15:0] prod  = {8'h00, req.a} * {8'h00, req.b};
  wire logic        ov_ad = (req.a[7] == req.b[7]) && (sum[7] != req.a[7]);
  wire logic        ov_sb = (req.a[7] != req.b[7]) && (dif[7] != req.a[7]);
  wire logic        is_ad = req.op == op_add || req.op == op_addc;
  wire logic        is_sb = req.op == op_subb;

  // ----------------------------------------
  // flag selection
  // ----------------------------------------
  // multiply and divide produce no carries, so both carries clear for them
  assign flags.carry = is_ad ? sum[8] : (is_sb ? dif[8] : 1'b0);
  assign flags.half  = is_ad ? hsum[4] : (is_sb ? hdif[4] : 1'b0);
  assign flags.ovf   = is_ad ? ov_ad :
                    is_sb ? ov_sb :
                    (req.op == op_mul) ? (|prod[15:8]) :
                    (req.op == op_div) ? (req.b == 8'h00) :
                    1'b0;

endmodule

// file: sim/tb.sv
// self-checking bench for the status word block
// assumes a zero-wait bus slave and the accumulator driven from here
`timescale 1ns/1ps
`include "status_word_map.svh"
module tb
  import status_word_pkg::*;
;
  typedef struct {int kind; logic [31:0] exp;} note_type;
  logic        sys_clk = 0, reset = 1, hsel = 0, hwrite = 0, hreadyout, hresp;
  logic [1:0]  htrans = 0;
  logic [2:0]  hsize = 3'h2, reg_index = 0;
  logic [31:0] haddr = 0, hwdata = 0, hrdata, rd, seed = 32'hAAC315CA;
  logic [7:0]  acc = 0, status_out, work_reg_addr, m = 0;
  alu_req_type alu_req = '0;
  bit_wr_type  bit_wr = '0;
  int          n_fail = 0, tests_run = 0;
  note_type    q[$];
  event        chk;

  status_word_flags dut_u (.sys_clk(sys_clk), .reset(reset), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
    .hresp(hresp), .hrdata(hrdata), .alu_req(alu_req), .bit_wr(bit_wr), .acc(acc),
    .reg_index(reg_index), .status_out(status_out), .work_reg_addr(work_reg_addr));

  always #12.5 sys_clk = ~sys_clk;

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  task automatic check(string nm, logic [31:0] s, logic [31:0] e);
    tests_run++;
    if (s !== e)
    begin
      n_fail++;
      $display("MISMATCH %s exp %h seen %h", nm, e, s);
    end
  endtask

  // one step lets the edge's updates land, so the watcher never races them
  task automatic note(int k, logic [31:0] e);
    #1;
    q.push_back('{k, e});
    ->chk;
  endtask

  always @(chk)
  begin
    note_type n;
    n = q.pop_front();
    if (n.kind == 0)
      check("status_out", {24'h0, status_out}, n.exp);
    else if (n.kind == 1)
      check("hrdata", rd & 32'hFFFF_FFFE, n.exp);
    else
      check("work_reg_addr", {24'h0, work_reg_addr}, n.exp);
  end

  task automatic bus(logic w, logic [31:0] a, logic [31:0] d);
    @(posedge sys_clk);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= w;
    htrans <= 2'h2;
    @(posedge sys_clk);
    while (hreadyout !== 1'b1) @(posedge sys_clk);
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge sys_clk);
    while (hreadyout !== 1'b1) @(posedge sys_clk);
    rd = hrdata;
  endtask

  task automatic wr(logic [31:0] a, logic [31:0] d);
    bus(1'b1, a, d);
    if (a == `STAT_ADDR) m[7:1] = d[7:1];
    note(0, {24'h0, m[7:1], ^acc});
  endtask

  task automatic rdw(logic [31:0] a);
    bus(1'b0, a, 32'h0);
    note(1, (a == `STAT_ADDR) ? {24'h0, m[7:1], 1'b0} : 32'h0);
  endtask

  task automatic bw(logic [2:0] sel, logic v);
    @(posedge sys_clk);
    bit_wr <= '{1'b1, sel, v};
    @(posedge sys_clk);
    bit_wr.valid <= 1'b0;
    if (sel != 3'h0) m[sel] = v;
    note(0, {24'h0, m[7:1], ^acc});
  endtask

  // flags worked out here from the arithmetic, not from the block
  task automatic alu(alu_op_type o, logic [7:0] a, logic [7:0] b);
    logic [8:0] s;
    logic       ci;
    ci = (o == op_addc || o == op_subb) && m[7];
    s = (o == op_subb) ? a - b - ci : a + b + ci;
    @(posedge sys_clk);
    alu_req <= '{1'b1, o, a, b};
    acc <= a ^ b;
    @(posedge sys_clk);
    alu_req.valid <= 1'b0;
    if (o == op_mul || o == op_div) m[7:6] = 2'b00;
    else m[7:6] = {s[8], (o == op_subb) ? {1'b0, a[3:0]} < {1'b0, b[3:0]} + ci : a[3:0] + b[3:0] + ci > 15};
    if (o == op_mul) m[2] = a * b > 255;
    else if (o == op_div) m[2] = b == 0;
    else if (o == op_subb) m[2] = a[7] != b[7] && s[7] != a[7];
    else m[2] = a[7] == b[7] && s[7] != a[7];
    note(0, {24'h0, m[7:1], ^(a ^ b)});
  endtask

  task automatic end_sim();
    $display("checks %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  // ----------------------------------------
  // tests
  // ----------------------------------------
  initial
  begin
    repeat (2) @(posedge sys_clk);
    reset <= 1'b0;
    rdw(`STAT_ADDR);
    rdw(32'hD4);
    wr(32'hD4, 32'hFF);
    wr(`STAT_ADDR, 32'hFF);
    rdw(`STAT_ADDR);
    $display("test register done");
    for (int i = 0; i < 8; i++) bw(3'(i), rnd() & 1);
    $display("test bit write done");
    for (int n = 0; n < 4; n++)
    begin
      @(posedge sys_clk) reg_index <= 3'(rnd());
      wr(`STAT_ADDR, {27'h0, 2'(n), 3'h0});
      note(2, {24'h0, 3'h0, m[4:3], reg_index});
    end
    $display("test bank done");
    alu(op_add, 8'h7F, 8'h01);
    alu(op_add, 8'hFF, 8'h01);
    alu(op_addc, 8'h00, 8'h00);
    alu(op_subb, 8'h80, 8'h01);
    alu(op_subb, 8'h00, 8'h01);
    alu(op_subb, 8'h10, 8'h00);
    alu(op_mul, 8'h10, 8'h10);
    alu(op_mul, 8'h0F, 8'h11);
    alu(op_div, 8'h05, 8'h00);
    alu(op_div, 8'h05, 8'h02);
    repeat (80) alu(alu_op_type'(3'(rnd() % 5)), 8'(rnd()), 8'(rnd()));
    $display("test arithmetic done");
    @(posedge sys_clk) reset <= 1'b1;
    @(posedge sys_clk) reset <= 1'b0;
    m = 8'h00;
    note(0, {24'h0, 7'h0, ^acc});
    $display("test second reset done");
    end_sim();
  end

  initial
  begin
    #(25 * 5000);
    n_fail++;
    end_sim();
  end
endmodule
